// ==== shared/iir_filter_defs.svh ====
/*
 Register offsets, reset values and arithmetic constants of the sensor output IIR filter.
 Assumes inclusion by its bare name from the filter package and the design file.
*/
`ifndef IIR_FILTER_DEFS_SVH
`define IIR_FILTER_DEFS_SVH

// Byte offsets on the AHB-Lite register port
`define OFS_COEF_A0 8'h00
`define OFS_COEF_A1 8'h04
`define OFS_COEF_A2 8'h08
`define OFS_COEF_B0 8'h0C
`define OFS_COEF_B1 8'h10
`define OFS_COEF_B2 8'h14
`define OFS_LOW_CLAMP 8'h18
`define OFS_HIGH_CLAMP 8'h1C
`define OFS_NORMAL_LOW 8'h20
`define OFS_NORMAL_HIGH 8'h24
`define OFS_DAC_CONFIG 8'h28
`define OFS_OUTPUT_STAGE 8'h2C
`define OFS_PRESSURE_GAIN 8'h30
`define OFS_TEMP_CONTROL 8'h34
`define OFS_STATUS 8'h38
`define OFS_OUTPUT_COUNT 8'h3C

// Reset values
`define RST_COEF 16'h0000
`define RST_LOW_CLAMP 16'h0334
`define RST_HIGH_CLAMP 16'h3CCF
`define RST_NORMAL_LOW 16'h0667
`define RST_NORMAL_HIGH 16'h399A
`define RST_DAC_CONFIG 8'h00
`define RST_OUTPUT_STAGE 8'h08
`define RST_PRESSURE_GAIN 8'h00
`define RST_TEMP_CONTROL 8'h40

// Arithmetic: coefficients are fixed point with 14 fraction bits
`define COEF_FRAC_BITS 14
`define COEF_BYPASS 16'h0000

// Status field positions
`define STATUS_LEVEL_LSB 16
`define STATUS_BYPASS_BIT 24

`endif

// ==== shared/iir_filter_pkg.sv ====
/*
 Types of the sensor output IIR filter: coefficient set, output configuration and FSM states.
 Assumes the constant header is on the include path.
*/
package iir_filter_pkg;
	`include "iir_filter_defs.svh"

	// Six filter coefficients, 16 bits each
	typedef struct packed {
		logic [15:0] a0;
		logic [15:0] a1;
		logic [15:0] a2;
		logic [15:0] b0;
		logic [15:0] b1;
		logic [15:0] b2;
	} coef_s;

	// Output converter and front-end settings handed to other blocks
	typedef struct packed {
		logic [7:0] dac_config;
		logic [7:0] output_stage_control;
		logic [7:0] pressure_gain_select;
		logic [7:0] temp_control;
		logic [15:0] normal_low;
		logic [15:0] normal_high;
	} out_cfg_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_STATE = 3'b010,
		ST_OUT = 3'b100
	} filt_state_e;
endpackage

// ==== design/sensor_output_iir_filter.sv ====
/*
 Sensor output IIR filter with its sample FIFO and AHB-Lite register slave.
 Assumes compensated samples and the AHB-Lite master share hclk; single slave, so
 hready is this slave's hreadyout; the output converter accepts with dac_ready.
*/
// Overview of operation
// - State sums a0 input, a1, a2 states
// - Output sums b0, b1, b2 state terms
// - Coefficient a0 zero bypasses the filter
// - Converter configuration byte resets to zero
// - Output stage byte resets to current loop
// - Normal low limit resets to 0667
// - Normal high limit resets to 399A
// - Pressure gain byte resets to zero
// - Temperature control byte resets to 40
// - Input clamped between low and high limits
`timescale 1ns/1ps
`include "iir_filter_defs.svh"

module sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	logic push;
	logic pop;

	// Honest flags straight from the occupancy count
	assign wr_ready = (count_r != (PW+1)'(DEPTH));
	assign rd_valid = (count_r != '0);
	assign push = wr_valid && wr_ready;
	assign pop = rd_valid && rd_ready;
	assign rd_data = mem_r[rd_ptr_r];
	assign level = count_r;

	// Storage has no reset; only words behind a valid count are ever read
	always_ff @(posedge hclk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= wr_data;
	end

	// Pointers and count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule

module sensor_output_iir_filter (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sample_valid,
	input wire logic [15:0] sample_data,
	output logic sample_ready,
	output logic dac_valid,
	input wire logic dac_ready,
	output logic [15:0] filtered_output_value,
	output iir_filter_pkg::out_cfg_s out_cfg
);
	import iir_filter_pkg::*;

	localparam int FIFO_DEPTH = 16;

	coef_s coef_r;
	out_cfg_s cfg_r;
	logic [15:0] low_clamp_r;
	logic [15:0] high_clamp_r;
	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] addr_r;
	logic [31:0] out_count_r;
	filt_state_e state_r;
	logic [15:0] x_r;
	logic signed [15:0] w0_r;
	logic signed [15:0] w1_r;
	logic signed [15:0] w2_r;
	logic [15:0] y_r;
	logic [15:0] clamped;
	logic fifo_valid;
	logic fifo_ready;
	logic [15:0] fifo_data;
	logic [4:0] fifo_level;
	logic bypass;
	logic signed [35:0] acc_w;
	logic signed [35:0] acc_y;
	logic signed [15:0] w_nxt;
	logic [15:0] y_nxt;
	logic addr_phase;

	// Saturate a wide signed sum to 16-bit signed
	function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
		logic signed [35:0] hi;
		logic signed [35:0] lo;
		hi = 36'sh0_0000_7FFF;
		lo = -36'sh0_0000_8000;
		if (v > hi)
			sat16 = 16'sh7FFF;
		else if (v < lo)
			sat16 = -16'sh8000;
		else
			sat16 = v[15:0];
	endfunction

	// Zero-wait slave; every transfer ends OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && hready && htrans[1];

	// Capture the address phase of each transfer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_r <= addr_phase && hwrite;
			rd_pend_r <= addr_phase && !hwrite;
			addr_r <= haddr[7:0];
		end
	end

	// Coefficient and configuration writes in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			coef_r <= {6{`RST_COEF}};
			low_clamp_r <= `RST_LOW_CLAMP;
			high_clamp_r <= `RST_HIGH_CLAMP;
			cfg_r.dac_config <= `RST_DAC_CONFIG;
			cfg_r.output_stage_control <= `RST_OUTPUT_STAGE;
			cfg_r.pressure_gain_select <= `RST_PRESSURE_GAIN;
			cfg_r.temp_control <= `RST_TEMP_CONTROL;
			cfg_r.normal_low <= `RST_NORMAL_LOW;
			cfg_r.normal_high <= `RST_NORMAL_HIGH;
		end
		else if (wr_pend_r)
		begin
			unique case (addr_r)
				`OFS_COEF_A0: coef_r.a0 <= hwdata[15:0];
				`OFS_COEF_A1: coef_r.a1 <= hwdata[15:0];
				`OFS_COEF_A2: coef_r.a2 <= hwdata[15:0];
				`OFS_COEF_B0: coef_r.b0 <= hwdata[15:0];
				`OFS_COEF_B1: coef_r.b1 <= hwdata[15:0];
				`OFS_COEF_B2: coef_r.b2 <= hwdata[15:0];
				`OFS_LOW_CLAMP: low_clamp_r <= hwdata[15:0];
				`OFS_HIGH_CLAMP: high_clamp_r <= hwdata[15:0];
				`OFS_NORMAL_LOW: cfg_r.normal_low <= hwdata[15:0];
				`OFS_NORMAL_HIGH: cfg_r.normal_high <= hwdata[15:0];
				`OFS_DAC_CONFIG: cfg_r.dac_config <= hwdata[7:0];
				`OFS_OUTPUT_STAGE: cfg_r.output_stage_control <= hwdata[7:0];
				`OFS_PRESSURE_GAIN: cfg_r.pressure_gain_select <= hwdata[7:0];
				`OFS_TEMP_CONTROL: cfg_r.temp_control <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	assign out_cfg = cfg_r;

	// Read mux over registered state; unmapped words read zero
	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (rd_pend_r)
		begin
			unique case (addr_r)
				`OFS_COEF_A0: hrdata = {16'h0000, coef_r.a0};
				`OFS_COEF_A1: hrdata = {16'h0000, coef_r.a1};
				`OFS_COEF_A2: hrdata = {16'h0000, coef_r.a2};
				`OFS_COEF_B0: hrdata = {16'h0000, coef_r.b0};
				`OFS_COEF_B1: hrdata = {16'h0000, coef_r.b1};
				`OFS_COEF_B2: hrdata = {16'h0000, coef_r.b2};
				`OFS_LOW_CLAMP: hrdata = {16'h0000, low_clamp_r};
				`OFS_HIGH_CLAMP: hrdata = {16'h0000, high_clamp_r};
				`OFS_NORMAL_LOW: hrdata = {16'h0000, cfg_r.normal_low};
				`OFS_NORMAL_HIGH: hrdata = {16'h0000, cfg_r.normal_high};
				`OFS_DAC_CONFIG: hrdata = {24'h00_0000, cfg_r.dac_config};
				`OFS_OUTPUT_STAGE: hrdata = {24'h00_0000, cfg_r.output_stage_control};
				`OFS_PRESSURE_GAIN: hrdata = {24'h00_0000, cfg_r.pressure_gain_select};
				`OFS_TEMP_CONTROL: hrdata = {24'h00_0000, cfg_r.temp_control};
				`OFS_STATUS:
				begin
					hrdata[15:0] = y_r;
					hrdata[`STATUS_LEVEL_LSB +: 5] = fifo_level;
					hrdata[`STATUS_BYPASS_BIT] = bypass;
				end
				`OFS_OUTPUT_COUNT: hrdata = out_count_r;
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_comb
	begin
		clamped = sample_data;
		if (sample_data < low_clamp_r)
			clamped = low_clamp_r;
		else if (sample_data > high_clamp_r)
			clamped = high_clamp_r;
	end

	// Buffer absorbs bursts while the converter stalls the filter
	sample_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_valid(sample_valid),
		.wr_ready(sample_ready),
		.wr_data(clamped),
		.rd_valid(fifo_valid),
		.rd_ready(fifo_ready),
		.rd_data(fifo_data),
		.level(fifo_level)
	);

	assign bypass = (coef_r.a0 == `COEF_BYPASS);
	assign fifo_ready = (state_r == ST_IDLE);

	always_comb
	begin
		acc_w = 36'(signed'(coef_r.a0) * signed'({1'b0, x_r}))
			+ 36'(signed'(coef_r.a1) * w0_r) // w0_r still holds w(n-1) here
			+ 36'(signed'(coef_r.a2) * w1_r);
		w_nxt = sat16(acc_w >>> `COEF_FRAC_BITS);
	end

	// output equation; negative results floor at zero
	always_comb
	begin
		acc_y = 36'(signed'({1'b0, coef_r.b0}) * w0_r)
			+ 36'(signed'({1'b0, coef_r.b1}) * w1_r)
			+ 36'(signed'({1'b0, coef_r.b2}) * w2_r);
		y_nxt = 16'h0000;
		if (sat16(acc_y >>> `COEF_FRAC_BITS) > 16'sh0000)
			y_nxt = sat16(acc_y >>> `COEF_FRAC_BITS);
	end

	// Sequencer: take a sample, update state, present output
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_r <= ST_IDLE;
		else
		begin
			unique case (state_r)
				ST_IDLE:
					if (fifo_valid)
						state_r <= ST_STATE;
				ST_STATE:
					state_r <= ST_OUT;
				ST_OUT:
					if (dac_ready && dac_valid)
						state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Sample latch
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			x_r <= 16'h0000;
		else if (state_r == ST_IDLE && fifo_valid)
			x_r <= fifo_data;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			w0_r <= 16'sh0000;
			w1_r <= 16'sh0000;
			w2_r <= 16'sh0000;
		end
		else if (state_r == ST_STATE)
		begin
			if (bypass)
			begin
				w0_r <= 16'sh0000;
				w1_r <= 16'sh0000;
				w2_r <= 16'sh0000;
			end
			else
			begin
				w0_r <= w_nxt;
				w1_r <= w0_r;
				w2_r <= w1_r;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			y_r <= 16'h0000;
		else if (state_r == ST_OUT && !dac_valid)
			y_r <= bypass ? x_r : y_nxt;
	end

	// Valid rises one cycle into ST_OUT so the output register has settled
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dac_valid <= 1'b0;
		else if (dac_valid && dac_ready)
			dac_valid <= 1'b0;
		else if (state_r == ST_OUT)
			dac_valid <= 1'b1;
	end

	// Delivered output count, wraps
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			out_count_r <= 32'h0000_0000;
		else if (dac_valid && dac_ready)
			out_count_r <= out_count_r + 32'h0000_0001;
	end

	assign filtered_output_value = y_r;
endmodule

// ==== tb/iir_filter_props.sv ====
/*
 Port checker for the sensor output IIR filter.
 Assumes it is bound to the top module and that everything runs on hclk.
*/
`timescale 1ns/1ps
module iir_filter_props
	import iir_filter_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic sample_valid,
	input wire logic [15:0] sample_data,
	input wire logic sample_ready,
	input wire logic dac_valid,
	input wire logic dac_ready,
	input wire logic [15:0] filtered_output_value,
	input wire iir_filter_pkg::out_cfg_s out_cfg
);
	logic rd_ph_r;
	logic wr_ph_r;
	logic [7:0] addr_r;

	// Data phase follows an accepted address phase by one cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_ph_r <= 1'b0;
			wr_ph_r <= 1'b0;
			addr_r <= 8'h00;
		end
		else
		begin
			rd_ph_r <= hsel && hready && htrans[1] && !hwrite;
			wr_ph_r <= hsel && hready && htrans[1] && hwrite;
			addr_r <= haddr[7:0];
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Converter handshake steps
	sequence held_s;
		dac_valid && !dac_ready;
	endsequence
	sequence gap_s;
		!dac_valid [*2];
	endsequence

	ready_const_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	rdata_idle_a: assert property (!rd_ph_r |-> hrdata == 32'h00000000)
		else $error("read data outside a read data phase");
	unmapped_read_a: assert property (rd_ph_r && addr_r == 8'h40 |-> hrdata == 32'h00000000)
		else $error("unmapped offset read nonzero");
	dac_hold_a: assert property (held_s |=> dac_valid && $stable(filtered_output_value))
		else $error("output dropped before acceptance");
	dac_accept_a: assert property ($fell(dac_valid) |-> $past(dac_ready))
		else $error("output withdrawn without ready");
	dac_gap_a: assert property ($fell(dac_valid) |-> gap_s)
		else $error("next output too soon");
	cfg_reset_a: assert property ($rose(hresetn) |-> out_cfg == 64'h00080040_0667399A)
		else $error("output config default wrong");
	cfg_write_a: assert property ($changed(out_cfg) |-> $past(wr_ph_r))
		else $error("output config changed without a write");
	ready_fall_a: assert property ($fell(sample_ready) |-> $past(sample_valid))
		else $error("sample ready fell with no sample offered");
endmodule

bind sensor_output_iir_filter iir_filter_props u_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
	.dac_valid(dac_valid), .dac_ready(dac_ready),
	.filtered_output_value(filtered_output_value), .out_cfg(out_cfg));

// ==== tb/testbench.sv ====
/*
 Self-checking bench for the sensor output IIR filter: registers, bypass, clamp, FIFO, taps.
 Assumes the bench is the only bus master and converter, so hready is the slave's hreadyout.
*/
`timescale 1ns/1ps
module testbench;
	import iir_filter_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic sample_valid = 1'b0;
	logic [15:0] sample_data = 16'h0;
	logic sample_ready;
	logic dac_valid;
	logic dac_ready = 1'b1;
	logic [15:0] filtered_output_value;
	out_cfg_s out_cfg;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] d;
	logic [15:0] ea [3] = '{16'h1000, 16'h1800, 16'h2000};
	logic [15:0] xb [3] = '{16'h0400, 16'h0500, 16'h0600};
	logic [15:0] eb [3] = '{16'h0400, 16'h0900, 16'h0F00};

	always #12.5 hclk = ~hclk;

	sensor_output_iir_filter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
		.sample_data(sample_data), .sample_ready(sample_ready), .dac_valid(dac_valid),
		.dac_ready(dac_ready), .filtered_output_value(filtered_output_value), .out_cfg(out_cfg));

	task automatic give_verdict();
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Ready and read data are taken at the rising edge, before that edge's updates land
	task automatic wait_rdy();
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		haddr <= {24'h0, a};
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= v;
		wait_rdy();
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b0;
		haddr <= {24'h0, a};
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		wait_rdy();
		chk(what, d, exp);
	endtask

	// Leaves valid up so that pushes can run back to back
	task automatic push(input logic [15:0] x);
		sample_valid <= 1'b1;
		sample_data <= x;
		do @(posedge hclk); while (sample_ready !== 1'b1);
	endtask

	task automatic get(input string what, input logic [15:0] exp);
		sample_valid <= 1'b0;
		do @(posedge hclk); while (dac_valid !== 1'b1);
		chk(what, {16'h0, filtered_output_value}, {16'h0, exp});
	endtask

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge hclk)
	begin
		cycles = cycles + 1;
		if (cycles > 20000)
		begin
			n_errors = n_errors + 1;
			give_verdict();
		end
	end

	initial
	begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("cfg_bytes", out_cfg[63:32], 32'h00080040);
		chk("cfg_limits", out_cfg[31:0], 32'h0667399A);
		rchk("normal_low", 8'h20, 32'h0667);
		rchk("normal_high", 8'h24, 32'h399A);
		rchk("dac_config", 8'h28, 32'h00);
		rchk("output_stage", 8'h2C, 32'h08);
		rchk("pressure_gain", 8'h30, 32'h00);
		rchk("temp_control", 8'h34, 32'h40);
		rchk("low_clamp", 8'h18, 32'h0334);
		rchk("high_clamp", 8'h1C, 32'h3CCF);
		rchk("a0", 8'h00, 32'h0);
		wr(8'h40, 32'hFFFF);
		rchk("unmapped", 8'h40, 32'h0);
		wr(8'h20, 32'h1234);
		rchk("normal_low", 8'h20, 32'h1234);
		chk("cfg_low", {16'h0, out_cfg.normal_low}, 32'h1234);
		// Mid-run reset must bring the written limit back to its default
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("cfg_low_rst", {16'h0, out_cfg.normal_low}, 32'h0667);
		push(16'h1234);
		get("bypass", 16'h1234);
		push(16'h0100);
		get("clamp_low", 16'h0334);
		push(16'hFFFF);
		get("clamp_high", 16'h3CCF);
		// Stalled converter: one word in flight plus sixteen stored
		dac_ready <= 1'b0;
		for (int i = 0; i < 17; i++)
			push(16'h0400 + 16'(i));
		@(posedge hclk);
		chk("fifo_full", {31'h0, sample_ready}, 32'h0);
		dac_ready <= 1'b1;
		for (int i = 0; i < 17; i++)
			get("drain", 16'h0400 + 16'(i));
		// Feedback taps with unity output gain
		wr(8'h00, 32'h4000);
		wr(8'h04, 32'h2000);
		wr(8'h08, 32'h1000);
		wr(8'h0C, 32'h4000);
		for (int i = 0; i < 3; i++)
		begin
			push(16'h1000);
			get("state", ea[i]);
		end
		// Bypass again also clears the history
		wr(8'h00, 32'h0000);
		push(16'h0500);
		get("bypass", 16'h0500);
		wr(8'h04, 32'h0000);
		wr(8'h08, 32'h0000);
		wr(8'h10, 32'h4000);
		wr(8'h14, 32'h4000);
		wr(8'h00, 32'h4000);
		for (int i = 0; i < 3; i++)
		begin
			push(xb[i]);
			get("output_taps", eb[i]);
		end
		// Last output F00, empty buffer, filter active; 27 outputs since the mid-run reset
		rchk("status", 8'h38, 32'h0000_0F00);
		rchk("out_count", 8'h3C, 32'd27);
		give_verdict();
	end
endmodule
